// ==== dv/ssc_clk_src.sv ====
// Model of the slow clock and the fast oscillator feeding the block
`timescale 1ns/10ps
module ssc_clk_src #(
  parameter int SLOW_HALF = 20,
  parameter int FAST_HALF = 2,
  parameter int SETTLE = 8
) (
  input wire logic core_clk,
  input wire logic osc_run,
  output logic slow_clk,
  output logic fast_clk
);
  int s_cnt = 0;
  int f_cnt = 0;
  int up_cnt = 0;
  logic slow_r = 1'b0;
  logic fast_r = 1'b0;
  // One driver for each output; both clocks start low
  assign slow_clk = slow_r;
  assign fast_clk = fast_r;
  // Slow clock runs free
  always @(posedge core_clk) begin
    s_cnt <= (s_cnt == SLOW_HALF - 1) ? 0 : s_cnt + 1;
    if (s_cnt == SLOW_HALF - 1) slow_r <= ~slow_r;
  end
  // Stopped oscillator stands low; no edges until it has settled
  always @(posedge core_clk) begin
    up_cnt <= osc_run ? ((up_cnt < SETTLE) ? up_cnt + 1 : up_cnt) : 0;
    if (!osc_run || up_cnt < SETTLE) begin
      fast_r <= 1'b0;
      f_cnt <= 0;
    end else begin
      f_cnt <= (f_cnt == FAST_HALF - 1) ? 0 : f_cnt + 1;
      if (f_cnt == FAST_HALF - 1) fast_r <= ~fast_r;
    end
  end
endmodule : ssc_clk_src

// ==== dv/system_speed_control_tb.sv ====
// Self-checking bench for the system speed control block
`timescale 1ns/10ps
`include "ssc_defs.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
  mismatches++; $display("CHECK FAILED t=%0t got %h exp %h", $time, \
  got, exp); end end
module system_speed_control_tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic slow_clk_in;
  logic fast_clock_input;
  logic [7:0] sel_n = 8'hff;
  logic sys_acc = 1'b0;
  logic [15:0] access_addr = 16'h0000;
  logic system_phase_clock;
  logic fast_osc_run;
  logic low_page_external;
  int mismatches = 0;
  int n_checks = 0;
  logic [7:0] d;

  always #4 core_clk = ~core_clk;

  ssc_speed_ctrl dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slow_clk_in(slow_clk_in),
    .fast_clock_input(fast_clock_input), .region_select_outputs_n(sel_n),
    .sys_select_access(sys_acc), .access_addr(access_addr),
    .system_phase_clock(system_phase_clock), .fast_osc_run(fast_osc_run),
    .low_page_external(low_page_external));

  ssc_clk_src osc_u (.core_clk(core_clk), .osc_run(fast_osc_run),
    .slow_clk(slow_clk_in), .fast_clk(fast_clock_input));

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  // Cycles until the phase clock flips; the first calls only resync
  task automatic half(output int n);
    logic p;
    p = system_phase_clock;
    n = 0;
    while (system_phase_clock === p && n < 400) begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask : half

  // Mode is latched at a toggle, so a few phases pass before measuring
  task automatic rate(input logic [7:0] c, input logic [7:0] s,
                      input logic acc, input int exp, input logic [1:0] m);
    int n;
    wr(`SSC_CTRL_ADDR, c);
    sel_n <= s;
    sys_acc <= acc;
    for (int i = 0; i < 3; i++) half(n);
    half(n);
    `CHK(n, exp)
    half(n);
    `CHK(n, exp)
    rd(`SSC_STAT_ADDR, d);
    `CHK(d[2:1], m)
  endtask : rate

  task automatic page(input logic [7:0] c, input logic [15:0] a,
                      input logic e);
    wr(`SSC_CTRL_ADDR, c);
    access_addr <= a;
    @(posedge core_clk);
    @(posedge core_clk);
    #1 `CHK(low_page_external, e)
  endtask : page

  initial begin
    #400000;
    mismatches++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(`SSC_CTRL_ADDR, d);
    `CHK(d, `SSC_CTRL_RESET)
    `CHK(fast_osc_run, 1'b0)
    rate(8'h00, 8'hff, 1'b0, 40, 2'b00);
    wr(`SSC_CTRL_ADDR, 8'h01);
    rd(`SSC_CTRL_ADDR, d);
    `CHK(d, 8'h01)
    `CHK(fast_osc_run, 1'b1)
    // Let the oscillator settle before it is used
    repeat (20) @(posedge core_clk);
    rate(8'h0b, 8'hff, 1'b1, 4, 2'b01);
    rate(8'h03, 8'hff, 1'b1, 16, 2'b10);
    for (int r = 4; r < 8; r++) begin
      rate(8'h0b, ~(8'h01 << r), 1'b1, 16, 2'b10);
      rate(8'h03 | (8'h01 << r), ~(8'h01 << r), 1'b1, 4, 2'b01);
    end
    // Oscillator stopped under a fast source, then running under the slow source: slow edges close the phases
    rate(8'h0a, 8'hff, 1'b1, 40, 2'b01);
    rate(8'h02, 8'hff, 1'b1, 40, 2'b10);
    rate(8'h01, 8'hff, 1'b0, 40, 2'b00);
    page(8'h04, 16'h01ff, 1'b1);
    page(8'h04, 16'h0200, 1'b0);
    page(8'h00, 16'h0000, 1'b0);
    page(8'h04, 16'h0000, 1'b1);
    // Unmapped place: write ignored, read gives zero
    wr(16'hdf40, 8'hff);
    rd(`SSC_CTRL_ADDR, d);
    `CHK(d, 8'h04)
    rd(16'hdf40, d);
    `CHK(d, 8'h00)
    // Reset in mid-run clears the register and stops the oscillator
    wr(`SSC_CTRL_ADDR, 8'h05);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(`SSC_CTRL_ADDR, d);
    `CHK(d, `SSC_CTRL_RESET)
    `CHK(fast_osc_run, 1'b0)
    `CHK(low_page_external, 1'b0)
    // Start, then stop: the gate must fall after the second write
    wr(`SSC_CTRL_ADDR, 8'h01);
    wr(`SSC_CTRL_ADDR, 8'h00);
    @(posedge core_clk);
    #1 `CHK(fast_osc_run, 1'b0)
    close_out();
  end
endmodule : system_speed_control_tb

// ==== rtl/ssc_defs.svh ====
// Address map, reset value, field positions and decode limits
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH

// Register addresses on the plain register port
`define SSC_CTRL_ADDR 16'hdf41
`define SSC_STAT_ADDR 16'hdf42

// Control register reset value
`define SSC_CTRL_RESET 8'h00

// Control register field positions
`define SSC_BIT_OSC_RUN 0
`define SSC_BIT_SRC 1
`define SSC_BIT_LOW_PAGE 2
`define SSC_BIT_ALL_SEL 3
`define SSC_REGION_FIRST 4
`define SSC_REGION_LAST 7

// Status register field positions
`define SSC_STAT_PHASE 0
`define SSC_STAT_MODE_LO 1
`define SSC_STAT_MODE_HI 2

// Top of the low page that may be moved to external RAM
`define SSC_LOW_PAGE_TOP 16'h01ff

// Last fast edge of a quarter-rate phase (four edges per phase)
`define SSC_QUARTER_LAST 2'h3

`endif

// ==== rtl/ssc_pkg.sv ====
// Types shared by the system speed control block
package ssc_pkg;

  // Rate of the phase clock for the phase in progress
  typedef enum logic [1:0] {
    ssc_mode_slow = 2'b00,
    ssc_mode_full = 2'b01,
    ssc_mode_quarter = 2'b10
  } ssc_mode_t;

endpackage : ssc_pkg

// ==== rtl/ssc_speed_ctrl.sv ====
// System speed control: control register and phase clock generation
`timescale 1ns/10ps
`include "ssc_defs.svh"

module ssc_speed_ctrl #(
  parameter int ADDR_W = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic slow_clk_in,
  input wire logic fast_clock_input,
  input wire logic [7:0] region_select_outputs_n,
  input wire logic sys_select_access,
  input wire logic [ADDR_W-1:0] access_addr,
  output logic system_phase_clock,
  output logic fast_osc_run,
  output logic low_page_external
);

  logic [7:0] speed_control_register_r;
  logic [7:0] reg_rdata_r;
  logic slow_q_r;
  logic fast_q_r;
  logic edges_armed_r;
  logic slow_tick;
  logic fast_edge;
  logic quarter_tick;
  logic phase_end;
  logic [1:0] div_cnt_r;
  logic phase_r;
  logic low_page_r;
  logic access_slow;
  ssc_pkg::ssc_mode_t mode_r;
  ssc_pkg::ssc_mode_t mode_nxt;

  // Decide whether the access in progress must run at quarter rate.
  // A selected region 4..7 follows its own bit; any other system
  // chip-select access follows the common bit; internal accesses run fast.
  function automatic logic ssc_is_slow(
    input logic [7:0] ctrl,
    input logic [7:0] sel_n,
    input logic sys_acc
  );
    logic slow;
    logic hit;
    slow = 1'b0;
    hit = 1'b0;
    for (int i = `SSC_REGION_FIRST; i <= `SSC_REGION_LAST; i++) begin
      if (!sel_n[i] && !hit) begin
        hit = 1'b1;
        slow = ~ctrl[i];
      end
    end
    if (!hit && sys_acc) begin
      slow = ~ctrl[`SSC_BIT_ALL_SEL];
    end
    return slow;
  endfunction : ssc_is_slow

  // Register writes; reset leaves the oscillator stopped
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      speed_control_register_r <= `SSC_CTRL_RESET;
    end else if (reg_wr && reg_addr == `SSC_CTRL_ADDR) begin
      speed_control_register_r <= reg_wdata;
    end
  end

  // Read data stand in the cycle after the strobe only
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd && reg_addr == `SSC_CTRL_ADDR) begin
      reg_rdata_r <= speed_control_register_r;
    end else if (reg_rd && reg_addr == `SSC_STAT_ADDR) begin
      reg_rdata_r <= {5'h00, mode_r, phase_r};
    end else begin
      reg_rdata_r <= 8'h00; // Unmapped or idle reads give zero
    end
  end

  assign reg_rdata = reg_rdata_r;

  // Oscillator gate follows the register bit directly
  assign fast_osc_run = speed_control_register_r[`SSC_BIT_OSC_RUN];

  // Low page decode, registered so the select is glitch free
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_page_r <= 1'b0;
    end else begin
      low_page_r <= speed_control_register_r[`SSC_BIT_LOW_PAGE] &&
                    (access_addr <= `SSC_LOW_PAGE_TOP);
    end
  end

  assign low_page_external = low_page_r;

  // Previous samples of both source clocks for edge detection
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      slow_q_r <= 1'b0;
      fast_q_r <= 1'b0;
    end else begin
      slow_q_r <= slow_clk_in;
      fast_q_r <= fast_clock_input;
    end
  end

  // Edge detection waits one cycle after reset: the samples are cleared
  // by reset, so a slow clock standing high would look like an edge
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      edges_armed_r <= 1'b0;
    end else begin
      edges_armed_r <= 1'b1;
    end
  end

  // Fast edges only count while the oscillator is enabled
  assign slow_tick = slow_clk_in & ~slow_q_r & edges_armed_r;
  assign fast_edge = fast_clock_input & ~fast_q_r & fast_osc_run &
                     edges_armed_r;
  assign quarter_tick = fast_edge && (div_cnt_r == `SSC_QUARTER_LAST);

  // Rate wanted for the next phase
  assign access_slow = ssc_is_slow(speed_control_register_r,
                                   region_select_outputs_n,
                                   sys_select_access);

  always_comb begin
    if (!speed_control_register_r[`SSC_BIT_SRC]) begin
      mode_nxt = ssc_pkg::ssc_mode_slow;
    end else if (access_slow) begin
      mode_nxt = ssc_pkg::ssc_mode_quarter;
    end else begin
      mode_nxt = ssc_pkg::ssc_mode_full;
    end
  end

  // End of the phase in progress, judged by the rate latched at its start.
  // If the oscillator is stopped under a fast phase, the slow clock ends
  // it late instead of hanging the processor; late is safe, short is not.
  always_comb begin
    case (mode_r)
      ssc_pkg::ssc_mode_slow: begin
        phase_end = slow_tick;
      end
      ssc_pkg::ssc_mode_full: begin
        phase_end = fast_edge | (~fast_osc_run & slow_tick);
      end
      ssc_pkg::ssc_mode_quarter: begin
        phase_end = quarter_tick | (~fast_osc_run & slow_tick);
      end
      default: begin
        phase_end = slow_tick;
      end
    endcase
  end

  // Quarter-rate divider restarts at each boundary so a new phase is whole
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt_r <= 2'h0;
    end else if (phase_end) begin
      div_cnt_r <= 2'h0;
    end else if (fast_edge) begin
      div_cnt_r <= div_cnt_r + 2'h1;
    end
  end

  // Phase clock toggles at boundaries; the rate is latched only there
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_r <= 1'b0;
      mode_r <= ssc_pkg::ssc_mode_slow;
    end else if (phase_end) begin
      phase_r <= ~phase_r;
      mode_r <= mode_nxt;
    end
  end

  assign system_phase_clock = phase_r;

  // Checks on the phase clock, the control register and the low page output

  // A quarter-rate phase with the oscillator running ends only on the fourth fast edge
  property p_quarter_len;
    @(posedge core_clk) disable iff (sys_rst)
    ($changed(phase_r) && $past(mode_r) == ssc_pkg::ssc_mode_quarter &&
     $past(fast_osc_run))
    |-> ($past(div_cnt_r) == `SSC_QUARTER_LAST && $past(fast_edge));
  endproperty
  a_quarter_len: assert property (p_quarter_len)
    else $error("quarter phase ended early");

  // A selected slow region 5 makes the next phase quarter rate
  property p_region_slow;
    @(posedge core_clk) disable iff (sys_rst)
    (phase_end && speed_control_register_r[`SSC_BIT_SRC] &&
     !region_select_outputs_n[5] && region_select_outputs_n[4] &&
     !speed_control_register_r[5])
    |=> mode_r == ssc_pkg::ssc_mode_quarter;
  endproperty
  a_region_slow: assert property (p_region_slow)
    else $error("slow region did not give quarter rate");

  // A fast system select with no region 4..7 gives full rate
  property p_sys_fast;
    @(posedge core_clk) disable iff (sys_rst)
    (phase_end && speed_control_register_r[`SSC_BIT_SRC] &&
     &region_select_outputs_n[7:4] && sys_select_access &&
     speed_control_register_r[`SSC_BIT_ALL_SEL])
    |=> mode_r == ssc_pkg::ssc_mode_full;
  endproperty
  a_sys_fast: assert property (p_sys_fast)
    else $error("fast system select did not give full rate");

  // Low page goes external one cycle after a hit with the bit set
  property p_low_page;
    @(posedge core_clk) disable iff (sys_rst)
    (access_addr <= `SSC_LOW_PAGE_TOP)
    |=> low_page_external ==
        $past(speed_control_register_r[`SSC_BIT_LOW_PAGE]);
  endproperty
  a_low_page: assert property (p_low_page)
    else $error("low page mapping wrong");

  // Source bit clear selects the slow clock for the next phase
  property p_slow_src;
    @(posedge core_clk) disable iff (sys_rst)
    (phase_end && !speed_control_register_r[`SSC_BIT_SRC])
    |=> mode_r == ssc_pkg::ssc_mode_slow;
  endproperty
  a_slow_src: assert property (p_slow_src)
    else $error("slow source not selected");

  // A write of the run bit reaches the oscillator gate next cycle
  property p_osc_gate;
    @(posedge core_clk) disable iff (sys_rst)
    (reg_wr && reg_addr == `SSC_CTRL_ADDR)
    |=> fast_osc_run == $past(reg_wdata[`SSC_BIT_OSC_RUN]);
  endproperty
  a_osc_gate: assert property (p_osc_gate)
    else $error("oscillator gate does not follow write");

  // The phase clock moves only on an edge of a source clock
  property p_boundary;
    @(posedge core_clk) disable iff (sys_rst)
    $changed(phase_r) |-> $past(slow_tick || fast_edge);
  endproperty
  a_boundary: assert property (p_boundary)
    else $error("phase clock moved without a source edge");

  // A slow phase ends only on a rising edge of the slow clock
  property p_slow_len;
    @(posedge core_clk) disable iff (sys_rst)
    ($changed(phase_r) && $past(mode_r) == ssc_pkg::ssc_mode_slow)
    |-> $past(slow_tick);
  endproperty
  a_slow_len: assert property (p_slow_len)
    else $error("slow phase ended without a slow edge");

  // A full-rate phase with the oscillator running lasts one fast edge
  property p_full_len;
    @(posedge core_clk) disable iff (sys_rst)
    ($changed(phase_r) && $past(mode_r) == ssc_pkg::ssc_mode_full &&
     $past(fast_osc_run))
    |-> $past(fast_edge);
  endproperty
  a_full_len: assert property (p_full_len)
    else $error("full phase ended without a fast edge");

  // With the oscillator stopped a fast phase is closed by the slow clock
  property p_osc_stopped;
    @(posedge core_clk) disable iff (sys_rst)
    (mode_r != ssc_pkg::ssc_mode_slow && !fast_osc_run && slow_tick)
    |=> $changed(phase_r);
  endproperty
  a_osc_stopped: assert property (p_osc_stopped)
    else $error("stopped oscillator left a fast phase hanging");

  // A selected fast region 4 gives full rate whatever the common bit says
  property p_region_fast;
    @(posedge core_clk) disable iff (sys_rst)
    (phase_end && speed_control_register_r[`SSC_BIT_SRC] &&
     !region_select_outputs_n[`SSC_REGION_FIRST] &&
     speed_control_register_r[`SSC_REGION_FIRST])
    |=> mode_r == ssc_pkg::ssc_mode_full;
  endproperty
  a_region_fast: assert property (p_region_fast)
    else $error("fast region did not give full rate");

  // A slow system select with no region 4..7 gives quarter rate
  property p_sys_slow;
    @(posedge core_clk) disable iff (sys_rst)
    (phase_end && speed_control_register_r[`SSC_BIT_SRC] &&
     &region_select_outputs_n[`SSC_REGION_LAST:`SSC_REGION_FIRST] &&
     sys_select_access && !speed_control_register_r[`SSC_BIT_ALL_SEL])
    |=> mode_r == ssc_pkg::ssc_mode_quarter;
  endproperty
  a_sys_slow: assert property (p_sys_slow)
    else $error("slow system select did not give quarter rate");

  // Addresses above the low page never go to external RAM here
  property p_low_page_above;
    @(posedge core_clk) disable iff (sys_rst)
    (access_addr > `SSC_LOW_PAGE_TOP) |=> !low_page_external;
  endproperty
  a_low_page_above: assert property (p_low_page_above)
    else $error("address above low page sent external");

  // Every new phase starts its quarter count from zero
  property p_div_restart;
    @(posedge core_clk) disable iff (sys_rst)
    phase_end |=> div_cnt_r == 2'h0;
  endproperty
  a_div_restart: assert property (p_div_restart)
    else $error("divider not cleared at phase boundary");

endmodule : ssc_speed_ctrl
